// file: hw/cdcmo_pkg.sv
// Constants and types of the converter mode and offset DAC control block
package cdcmo_pkg;
	localparam logic [7:0] ADDR_STATUS  = 8'h00;
	localparam logic [7:0] ADDR_DATA1_HI = 8'h01;
	localparam logic [7:0] ADDR_DATA1_LO = 8'h02;
	localparam logic [7:0] ADDR_DATA2_HI = 8'h03;
	localparam logic [7:0] ADDR_DATA2_LO = 8'h04;
	localparam logic [7:0] ADDR_CONFIG  = 8'h0f;
	localparam logic [7:0] ADDR_DAC_POS = 8'h11;
	localparam logic [7:0] ADDR_DAC_NEG = 8'h12;
	localparam logic [7:0] ADDR_FILTER  = 8'h1a;

	localparam logic [7:0]  RESET_CONFIG = 8'h00;
	localparam logic [7:0]  RESET_DAC    = 8'h00;
	localparam logic [7:0]  RESET_FILTER = 8'h00;
	localparam logic [15:0] RESET_DATA   = 16'h0000;

	// Writable bits; unused positions are held at zero
	localparam logic [7:0] MASK_CONFIG = 8'h1f;
	localparam logic [7:0] MASK_DAC    = 8'h9f;
	localparam logic [7:0] MASK_FILTER = 8'h30;

	localparam int CH1_EN_BIT      = 4;
	localparam int CH2_EN_BIT      = 3;
	localparam int MODE_MSB        = 2;
	localparam int DAC_CONNECT_BIT = 7;
	localparam int DAC_LEVEL_MSB   = 4;
	localparam int RATE_HI_BIT     = 5;
	localparam int RATE_LO_BIT     = 4;

	localparam logic [2:0] MODE_IDLE    = 3'h0;
	localparam logic [2:0] MODE_CONT    = 3'h1;
	localparam logic [2:0] MODE_SINGLE  = 3'h2;
	localparam logic [2:0] MODE_PDOWN   = 3'h3;
	localparam logic [2:0] MODE_OFFCAL  = 3'h5;
	localparam logic [2:0] MODE_GAINCAL = 3'h6;

	// Conversion times in ms per rate code, clock in kHz
	localparam int CLK_KHZ   = 250000;
	localparam int CONV_MS_0 = 5;
	localparam int CONV_MS_1 = 20;
	localparam int CONV_MS_2 = 50;
	localparam int CONV_MS_3 = 60;
	localparam int CONV_CYC_0 = CONV_MS_0 * CLK_KHZ;
	localparam int CONV_CYC_1 = CONV_MS_1 * CLK_KHZ;
	localparam int CONV_CYC_2 = CONV_MS_2 * CLK_KHZ;
	localparam int CONV_CYC_3 = CONV_MS_3 * CLK_KHZ;
	localparam int CNT_W = 24;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_CONVERT = 3'b010,
		ST_POWER   = 3'b100
	} cdcmo_state_type;

	function automatic logic is_conv_mode(input logic [2:0] mode);
		is_conv_mode = (mode == MODE_CONT) || (mode == MODE_SINGLE) ||
			(mode == MODE_OFFCAL) || (mode == MODE_GAINCAL);
	endfunction : is_conv_mode

	function automatic logic data_addr_hit(input logic [7:0] addr, input logic ch);
		data_addr_hit = ch ? (addr == ADDR_DATA2_HI || addr == ADDR_DATA2_LO)
			: (addr == ADDR_DATA1_HI || addr == ADDR_DATA1_LO);
	endfunction : data_addr_hit
endpackage : cdcmo_pkg

// file: hw/cdcmo_timer_if.sv
// Handshake between sequencer and conversion timer
`timescale 1ns/10ps
interface cdcmo_timer_if;
	logic       start;
	logic [1:0] rate;
	logic       done;
	modport ctrl  (output start, output rate, input done);
	modport timer (input start, input rate, output done);
endinterface : cdcmo_timer_if

// file: hw/cdcmo_conv_timer.sv
// Conversion time counter for one channel conversion
`timescale 1ns/10ps
module cdcmo_conv_timer #(
	parameter int unsigned CYC_0 = cdcmo_pkg::CONV_CYC_0,
	parameter int unsigned CYC_1 = cdcmo_pkg::CONV_CYC_1,
	parameter int unsigned CYC_2 = cdcmo_pkg::CONV_CYC_2,
	parameter int unsigned CYC_3 = cdcmo_pkg::CONV_CYC_3
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	cdcmo_timer_if.timer     tmr
);
	logic [cdcmo_pkg::CNT_W-1:0] count;
	logic                        busy;
	logic [cdcmo_pkg::CNT_W-1:0] next_count;

	// Rate is latched at start, so a filter change applies to the next conversion
	always_comb begin
		unique case (tmr.rate)
			2'h0: next_count = cdcmo_pkg::CNT_W'(CYC_0 - 1);
			2'h1: next_count = cdcmo_pkg::CNT_W'(CYC_1 - 1);
			2'h2: next_count = cdcmo_pkg::CNT_W'(CYC_2 - 1);
			2'h3: next_count = cdcmo_pkg::CNT_W'(CYC_3 - 1);
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			count    <= '0;
			busy     <= 1'b0;
			tmr.done <= 1'b0;
		end else if (tmr.start) begin
			count    <= next_count;
			busy     <= 1'b1;
			tmr.done <= 1'b0;
		end else if (busy && count == '0) begin
			busy     <= 1'b0;
			tmr.done <= 1'b1;
		end else begin
			count    <= busy ? count - 1'b1 : count;
			tmr.done <= 1'b0;
		end
	end
endmodule : cdcmo_conv_timer

// file: hw/cdcmo_ctrl.sv
// Mode, channel sequencing and offset DAC control of the capacitance converter
//
// Behaviour
// - Config bit 4 enables channel one, bit 3 channel two; only enabled channels convert.
// - Mode bits 2..0: idle, continuous, single, power-down, offset cal, gain cal.
// - Conversion config at pointer 0x0F resets to 0x00: channels off, idle.
// - Positive DAC register bit 7 connects the positive offset DAC.
// - Negative DAC register bit 7 connects the negative offset DAC.
// - Positive DAC bits 4..0 set its level, 0x00 none, 0x1F full.
// - Negative DAC bits 4..0 set its level, 0x00 none, 0x1F full.
// - Filter bits 5..4 pick conversion time 5, 20, 50 or 60 ms.
// - Modulator input and excitation follow the channel now converting.
// - Each channel has an active-low ready flag, low while unread data waits.
// - A result arriving during a serial read of that data register is dropped.
// - Both DACs are shared; host reloads them before converting another channel.
`timescale 1ns/10ps
module cdcmo_ctrl #(
	parameter int unsigned CONV_CYC_0 = cdcmo_pkg::CONV_CYC_0,
	parameter int unsigned CONV_CYC_1 = cdcmo_pkg::CONV_CYC_1,
	parameter int unsigned CONV_CYC_2 = cdcmo_pkg::CONV_CYC_2,
	parameter int unsigned CONV_CYC_3 = cdcmo_pkg::CONV_CYC_3
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic        host_read_active,
	input  wire logic [11:0] conv_data,
	output logic      [7:0]  reg_rdata,
	output logic             first_channel_ready_n,
	output logic             second_channel_ready_n,
	output logic             pos_offset_dac_connect,
	output logic      [4:0]  pos_offset_dac_level,
	output logic             neg_offset_dac_connect,
	output logic      [4:0]  neg_offset_dac_level,
	output logic             filter_rate_sel_hi,
	output logic             filter_rate_sel_lo,
	output logic             mux_channel_sel,
	output logic      [1:0]  excitation_enable,
	output logic             modulator_enable,
	output logic             power_down
);
	logic [7:0]                 conversion_config;
	logic [7:0]                 positive_offset_dac;
	logic [7:0]                 negative_offset_dac;
	logic [7:0]                 filter_rate_config;
	logic [15:0]                data_ch [2];
	logic                       last_ch;
	cdcmo_pkg::cdcmo_state_type state;
	logic                       active_ch;
	logic [2:0]                 mode;
	logic                       first_channel_enable;
	logic                       second_channel_enable;
	logic                       is_last;
	logic                       finish_one_shot;
	logic                       store;
	logic                       discard;

	cdcmo_timer_if tmr ();

	cdcmo_conv_timer #(
		.CYC_0 (CONV_CYC_0),
		.CYC_1 (CONV_CYC_1),
		.CYC_2 (CONV_CYC_2),
		.CYC_3 (CONV_CYC_3)
	) u_timer (
		.ref_clk (ref_clk),
		.reset   (reset),
		.tmr     (tmr)
	);

	assign mode                  = conversion_config[cdcmo_pkg::MODE_MSB:0];
	assign first_channel_enable  = conversion_config[cdcmo_pkg::CH1_EN_BIT];
	assign second_channel_enable = conversion_config[cdcmo_pkg::CH2_EN_BIT];
	assign is_last         = active_ch || !second_channel_enable;
	// An abort by a host write keeps the mode that the host chose
	assign finish_one_shot = state == cdcmo_pkg::ST_CONVERT && tmr.done && is_last &&
		cdcmo_pkg::is_conv_mode(mode) && mode != cdcmo_pkg::MODE_CONT;
	assign discard = host_read_active && cdcmo_pkg::data_addr_hit(reg_addr, active_ch);
	assign store   = state == cdcmo_pkg::ST_CONVERT && tmr.done && !discard;
	assign tmr.rate = {filter_rate_config[cdcmo_pkg::RATE_HI_BIT],
		filter_rate_config[cdcmo_pkg::RATE_LO_BIT]};

	// Register writes; host write outranks the automatic return to idle
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			conversion_config   <= cdcmo_pkg::RESET_CONFIG;
			positive_offset_dac <= cdcmo_pkg::RESET_DAC;
			negative_offset_dac <= cdcmo_pkg::RESET_DAC;
			filter_rate_config  <= cdcmo_pkg::RESET_FILTER;
		end else if (reg_wr) begin
			unique case (reg_addr)
				cdcmo_pkg::ADDR_CONFIG:
					conversion_config <= reg_wdata & cdcmo_pkg::MASK_CONFIG;
				cdcmo_pkg::ADDR_DAC_POS:
					positive_offset_dac <= reg_wdata & cdcmo_pkg::MASK_DAC;
				cdcmo_pkg::ADDR_DAC_NEG:
					negative_offset_dac <= reg_wdata & cdcmo_pkg::MASK_DAC;
				cdcmo_pkg::ADDR_FILTER:
					filter_rate_config <= reg_wdata & cdcmo_pkg::MASK_FILTER;
				default: ;
			endcase
		end else if (finish_one_shot) begin
			conversion_config[cdcmo_pkg::MODE_MSB:0] <= cdcmo_pkg::MODE_IDLE;
		end
	end

	// Shared DACs drive both channels; no per-channel copy exists
	assign pos_offset_dac_connect = positive_offset_dac[cdcmo_pkg::DAC_CONNECT_BIT];
	assign neg_offset_dac_connect = negative_offset_dac[cdcmo_pkg::DAC_CONNECT_BIT];
	assign pos_offset_dac_level = positive_offset_dac[cdcmo_pkg::DAC_LEVEL_MSB:0];
	assign neg_offset_dac_level = negative_offset_dac[cdcmo_pkg::DAC_LEVEL_MSB:0];
	assign filter_rate_sel_hi = filter_rate_config[cdcmo_pkg::RATE_HI_BIT];
	assign filter_rate_sel_lo = filter_rate_config[cdcmo_pkg::RATE_LO_BIT];

	// Channel sequencer; undefined mode codes behave as idle
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state     <= cdcmo_pkg::ST_IDLE;
			active_ch <= 1'b0;
			tmr.start <= 1'b0;
		end else begin
			tmr.start <= 1'b0;
			unique case (state)
				cdcmo_pkg::ST_IDLE: begin
					if (mode == cdcmo_pkg::MODE_PDOWN) begin
						state <= cdcmo_pkg::ST_POWER;
					end else if (cdcmo_pkg::is_conv_mode(mode) &&
							(first_channel_enable || second_channel_enable)) begin
						state     <= cdcmo_pkg::ST_CONVERT;
						active_ch <= !first_channel_enable;
						tmr.start <= 1'b1;
					end
				end
				cdcmo_pkg::ST_CONVERT: begin
					if (!cdcmo_pkg::is_conv_mode(mode)) begin
						state <= cdcmo_pkg::ST_IDLE;
					end else if (tmr.done && !is_last) begin
						active_ch <= 1'b1;
						tmr.start <= 1'b1;
					end else if (tmr.done && mode == cdcmo_pkg::MODE_CONT &&
							(first_channel_enable || second_channel_enable)) begin
						active_ch <= !first_channel_enable;
						tmr.start <= 1'b1;
					end else if (tmr.done) begin
						state <= cdcmo_pkg::ST_IDLE;
					end
				end
				cdcmo_pkg::ST_POWER: begin
					if (mode != cdcmo_pkg::MODE_PDOWN) begin
						state <= cdcmo_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Analog routing follows the converting channel
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mux_channel_sel   <= 1'b0;
			excitation_enable <= 2'h0;
			modulator_enable  <= 1'b0;
			power_down        <= 1'b0;
		end else begin
			mux_channel_sel   <= active_ch;
			excitation_enable <= (state == cdcmo_pkg::ST_CONVERT) ?
				(active_ch ? 2'h2 : 2'h1) : 2'h0;
			modulator_enable  <= state == cdcmo_pkg::ST_CONVERT;
			power_down        <= state == cdcmo_pkg::ST_POWER;
		end
	end

	// Results and ready flags; a new result wins over a same-cycle read clear
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			data_ch[0]             <= cdcmo_pkg::RESET_DATA;
			data_ch[1]             <= cdcmo_pkg::RESET_DATA;
			last_ch                <= 1'b0;
			first_channel_ready_n  <= 1'b1;
			second_channel_ready_n <= 1'b1;
		end else begin
			if (store) begin
				data_ch[active_ch] <= {conv_data, 4'h0};
				last_ch            <= active_ch;
			end
			if (store && !active_ch) begin
				first_channel_ready_n <= 1'b0;
			end else if (reg_rd && reg_addr == cdcmo_pkg::ADDR_DATA1_LO) begin
				first_channel_ready_n <= 1'b1;
			end
			if (store && active_ch) begin
				second_channel_ready_n <= 1'b0;
			end else if (reg_rd && reg_addr == cdcmo_pkg::ADDR_DATA2_LO) begin
				second_channel_ready_n <= 1'b1;
			end
		end
	end

	// Read port; unmapped pointers read zero
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				cdcmo_pkg::ADDR_STATUS: reg_rdata <= {state == cdcmo_pkg::ST_POWER, 4'h0,
					last_ch, second_channel_ready_n, first_channel_ready_n};
				cdcmo_pkg::ADDR_DATA1_HI: reg_rdata <= data_ch[0][15:8];
				cdcmo_pkg::ADDR_DATA1_LO: reg_rdata <= data_ch[0][7:0];
				cdcmo_pkg::ADDR_DATA2_HI: reg_rdata <= data_ch[1][15:8];
				cdcmo_pkg::ADDR_DATA2_LO: reg_rdata <= data_ch[1][7:0];
				cdcmo_pkg::ADDR_CONFIG:   reg_rdata <= conversion_config;
				cdcmo_pkg::ADDR_DAC_POS:  reg_rdata <= positive_offset_dac;
				cdcmo_pkg::ADDR_DAC_NEG:  reg_rdata <= negative_offset_dac;
				cdcmo_pkg::ADDR_FILTER:   reg_rdata <= filter_rate_config;
				default:                  reg_rdata <= 8'h00;
			endcase
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence write_to(logic [7:0] a);
		reg_wr && reg_addr == a;
	endsequence

	chk_reset_config: assert property (@(posedge ref_clk) disable iff (1'b0)
		reset |=> conversion_config == 8'h00)
		else $error("config not cleared by reset");
	chk_enabled_only: assert property (tmr.start && $stable(conversion_config) |->
		conversion_config[active_ch ? cdcmo_pkg::CH2_EN_BIT : cdcmo_pkg::CH1_EN_BIT])
		else $error("disabled channel converting");
	chk_mode_decode: assert property (state == cdcmo_pkg::ST_CONVERT ##1
		state == cdcmo_pkg::ST_CONVERT |-> $past(cdcmo_pkg::is_conv_mode(mode)))
		else $error("converting in non-conversion mode");
	chk_pos_dac: assert property (write_to(cdcmo_pkg::ADDR_DAC_POS) |=>
		pos_offset_dac_connect == $past(reg_wdata[7]) &&
		pos_offset_dac_level == $past(reg_wdata[4:0]))
		else $error("positive DAC not updated");
	chk_neg_dac: assert property (write_to(cdcmo_pkg::ADDR_DAC_NEG) |=>
		neg_offset_dac_connect == $past(reg_wdata[7]) &&
		neg_offset_dac_level == $past(reg_wdata[4:0]))
		else $error("negative DAC not updated");
	chk_rate_select: assert property (write_to(cdcmo_pkg::ADDR_FILTER) |=>
		{filter_rate_sel_hi, filter_rate_sel_lo} == $past(reg_wdata[5:4]))
		else $error("rate select not updated");
	chk_mux_route: assert property (state == cdcmo_pkg::ST_CONVERT ##1 1'b1 |->
		excitation_enable == ($past(active_ch) ? 2'h2 : 2'h1) &&
		mux_channel_sel == $past(active_ch) && modulator_enable)
		else $error("routing does not follow channel");
	chk_ready_flag: assert property (store |=>
		(($past(active_ch) ? second_channel_ready_n : first_channel_ready_n) == 1'b0))
		else $error("ready flag not set on result");
	chk_read_discard: assert property (state == cdcmo_pkg::ST_CONVERT && tmr.done && discard
		|=> $stable(data_ch[0]) && $stable(data_ch[1]))
		else $error("result stored during read");
	chk_return_idle: assert property (finish_one_shot && !reg_wr |=>
		conversion_config[2:0] == 3'h0 ##1 state == cdcmo_pkg::ST_IDLE)
		else $error("mode not returned to idle");
endmodule : cdcmo_ctrl

// file: testbench/cdcmo_host_model.sv
// Host controller model driving the register port of the converter
`timescale 1ns/10ps
module cdcmo_host_model (
	input  wire logic       ref_clk,
	input  wire logic [7:0] reg_rdata,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic            host_read_active
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		host_read_active = 1'b0;
	end

	// Callers pass zeros in unused bits except where a refusal is wanted
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		// Stale data would hide a late sample
		reg_wdata = ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask : rd

	// Serial read in progress up to the stop condition
	task automatic hold(input logic [7:0] a, input logic act);
		@(negedge ref_clk);
		reg_addr = a;
		host_read_active = act;
	endtask : hold
endmodule : cdcmo_host_model

// file: testbench/cdcmo_ctrl_bench.sv
// Self-checking bench of the mode and offset DAC control block
`timescale 1ns/10ps
module cdcmo_ctrl_bench;
	typedef struct packed {
		logic [7:0]  addr;
		logic [7:0]  data;
		logic [7:0]  back;
		logic [13:0] outs;
	} cdcmo_row_type;

	logic          ref_clk, reset, reg_wr, reg_rd, host_read_active;
	logic [7:0]    reg_addr, reg_wdata, reg_rdata, rb;
	logic [11:0]   conv_data;
	logic          first_channel_ready_n, second_channel_ready_n;
	logic          pos_offset_dac_connect, neg_offset_dac_connect;
	logic [4:0]    pos_offset_dac_level, neg_offset_dac_level;
	logic          filter_rate_sel_hi, filter_rate_sel_lo, mux_channel_sel;
	logic [1:0]    excitation_enable;
	logic          modulator_enable, power_down, c;
	int            miscompares, tests_run, n;
	cdcmo_row_type rows [0:10] = '{
		'{8'h11, 8'h85, 8'h85, 14'h2500}, '{8'h11, 8'he5, 8'h85, 14'h2500},
		'{8'h11, 8'h1f, 8'h1f, 14'h1f00}, '{8'h12, 8'h9f, 8'h9f, 14'h1ffc},
		'{8'h11, 8'h00, 8'h00, 14'h00fc}, '{8'h12, 8'h80, 8'h80, 14'h0080},
		'{8'h1a, 8'h30, 8'h30, 14'h0083}, '{8'h1a, 8'h10, 8'h10, 14'h0081},
		'{8'h1a, 8'h20, 8'h20, 14'h0082}, '{8'h1a, 8'hc0, 8'h00, 14'h0080},
		'{8'h12, 8'h00, 8'h00, 14'h0000}};

	cdcmo_host_model u_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.host_read_active(host_read_active));

	// Short counts keep the run small; expectations follow these values
	cdcmo_ctrl #(.CONV_CYC_0(20), .CONV_CYC_1(40), .CONV_CYC_2(60), .CONV_CYC_3(80)) u_dut (
		.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .host_read_active(host_read_active),
		.conv_data(conv_data), .reg_rdata(reg_rdata),
		.first_channel_ready_n(first_channel_ready_n),
		.second_channel_ready_n(second_channel_ready_n),
		.pos_offset_dac_connect(pos_offset_dac_connect),
		.pos_offset_dac_level(pos_offset_dac_level),
		.neg_offset_dac_connect(neg_offset_dac_connect),
		.neg_offset_dac_level(neg_offset_dac_level),
		.filter_rate_sel_hi(filter_rate_sel_hi), .filter_rate_sel_lo(filter_rate_sel_lo),
		.mux_channel_sel(mux_channel_sel), .excitation_enable(excitation_enable),
		.modulator_enable(modulator_enable), .power_down(power_down));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, rb);
		chk({8'h00, rb}, {8'h00, e});
	endtask : rc

	task automatic wait_rdy(input logic ch, output int k);
		for (k = 0; k < 400; k++) begin
			if ((ch ? second_channel_ready_n : first_channel_ready_n) === 1'b0)
				break;
			@(negedge ref_clk);
		end
	endtask : wait_rdy

	task automatic close_out();
		if (miscompares == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	task automatic routing(input logic [4:0] e);
		chk({11'h0, mux_channel_sel, excitation_enable, modulator_enable, power_down},
			{11'h0, e});
	endtask : routing

	initial begin
		#100000;
		miscompares++;
		close_out();
	end

	initial begin
		reset = 1'b1;
		conv_data = 12'habc;
		repeat (16) @(negedge ref_clk);
		reset = 1'b0;
		chk({14'h0, first_channel_ready_n, second_channel_ready_n}, 16'h0003);
		routing(5'h00);
		rc(8'h0f, 8'h00);
		rc(8'h11, 8'h00);
		rc(8'h12, 8'h00);
		rc(8'h1a, 8'h00);
		rc(8'h00, 8'h03);
		foreach (rows[i]) begin
			u_host.wr(rows[i].addr, rows[i].data);
			rc(rows[i].addr, rows[i].back);
			chk({2'b00, pos_offset_dac_connect, pos_offset_dac_level, neg_offset_dac_connect,
				neg_offset_dac_level, filter_rate_sel_hi, filter_rate_sel_lo},
				{2'b00, rows[i].outs});
		end
		for (int m = 0; m < 8; m++) begin
			c = (m == 1 || m == 2 || m == 5 || m == 6);
			u_host.wr(8'h0f, 8'h10 | 8'(m));
			repeat (3) @(negedge ref_clk);
			routing({1'b0, 1'b0, c, c, m == 3});
			u_host.wr(8'h0f, 8'h00);
			repeat (3) @(negedge ref_clk);
		end
		u_host.wr(8'h0f, 8'h01);
		repeat (3) @(negedge ref_clk);
		routing(5'h00);
		for (int r = 0; r < 4; r++) begin
			u_host.wr(8'h1a, {2'b00, r[1:0], 4'h0});
			// Single, offset cal, gain cal, single: all must fall back to idle
			u_host.wr(8'h0f, r == 1 ? 8'h15 : (r == 2 ? 8'h16 : 8'h12));
			wait_rdy(1'b0, n);
			chk({15'h0, n >= 20 * (r + 1) && n <= 20 * (r + 1) + 8}, 16'h0001);
			rc(8'h0f, 8'h10);
			rc(8'h02, 8'hc0);
			chk({15'h0, first_channel_ready_n}, 16'h0001);
		end
		u_host.wr(8'h1a, 8'h00);
		u_host.wr(8'h11, 8'h9a);
		u_host.wr(8'h0f, 8'h1a);
		repeat (3) @(negedge ref_clk);
		routing(5'b00110);
		wait_rdy(1'b0, n);
		repeat (4) @(negedge ref_clk);
		routing(5'b11010);
		wait_rdy(1'b1, n);
		rc(8'h00, 8'h04);
		rc(8'h0f, 8'h18);
		rc(8'h03, 8'hab);
		rc(8'h04, 8'hc0);
		chk({14'h0, first_channel_ready_n, second_channel_ready_n}, 16'h0001);
		chk({8'h00, pos_offset_dac_connect, 2'b00, pos_offset_dac_level}, 16'h009a);
		// Clear the channel one flag so the discard case starts from no unread data
		rc(8'h02, 8'hc0);
		// Pointer parked on the data register throughout a conversion end
		conv_data = 12'h123;
		u_host.hold(8'h01, 1'b1);
		u_host.wr(8'h0f, 8'h11);
		u_host.hold(8'h01, 1'b1);
		repeat (40) @(negedge ref_clk);
		chk({15'h0, first_channel_ready_n}, 16'h0001);
		rc(8'h01, 8'hab);
		u_host.hold(8'h00, 1'b0);
		repeat (2) @(negedge ref_clk);
		wait_rdy(1'b0, n);
		rc(8'h01, 8'h12);
		rc(8'h02, 8'h30);
		reset = 1'b1;
		repeat (2) @(negedge ref_clk);
		reset = 1'b0;
		rc(8'h0f, 8'h00);
		rc(8'h00, 8'h03);
		routing(5'h00);
		close_out();
	end
endmodule : cdcmo_ctrl_bench
